// *** adcp_pkg.sv ***
// package: register map, field layout, reset values and timing of the output control block
package adcp_pkg;
  // register addresses on the serial port
  localparam logic [9:0] A_PWR   = 10'h000;
  localparam logic [9:0] A_RAND  = 10'h007;
  localparam logic [9:0] A_PHDLL = 10'h052;
  localparam logic [9:0] A_PHDEC = 10'h053;
  localparam logic [9:0] A_OMODE = 10'h062;
  localparam logic [9:0] A_PHEN  = 10'h064;
  localparam logic [9:0] A_LANE  = 10'h069;
  localparam logic [9:0] A_PLL   = 10'h06d;
  localparam logic [9:0] A_UP0   = 10'h074;
  localparam logic [9:0] A_UP3   = 10'h077;
  localparam logic [9:0] A_CAL   = 10'h0c0;
  // field positions
  localparam int unsigned B_SOFT = 0;
  localparam int unsigned B_RAND = 0;
  localparam int unsigned B_PHEN = 0;
  localparam int unsigned B_TP   = 2;
  // values after reset
  localparam logic [7:0] RV_PWR   = 8'h01;
  localparam logic [7:0] RV_OMODE = 8'h01;
  localparam logic [7:0] RV_LANE  = 8'hff;
  localparam logic [7:0] RV_ZERO  = 8'h00;
  // output word timing: eight clocks per word, two halves
  localparam logic [2:0] PH_LAST = 3'h7;
  localparam logic [2:0] PH_MID  = 3'h3;
  // pattern constants
  localparam logic [15:0] PN_SEED = 16'hffff;
  localparam logic [13:0] CHK_A   = 14'h2aaa;
  localparam logic [13:0] CHK_B   = 14'h1555;
  // calibration lengths in sample clocks
  localparam logic [31:0] CAL_PWRUP_CYC = 32'h0c00_0000;
  localparam logic [31:0] CAL_BG_CYC    = 32'h4000_0000;
  // serial framing
  localparam logic [3:0] HDR_LAST  = 4'hf;
  localparam logic [2:0] BYTE_LAST = 3'h7;
  // output modes, test patterns, calibration states
  typedef enum logic [1:0] {OM_OFF = 2'b00, OM_CMOS = 2'b01, OM_LVDS = 2'b10,
                            OM_LVDS_B = 2'b11} adcp_om_e;
  typedef enum logic [2:0] {TP_NONE = 3'b000, TP_ZERO = 3'b001, TP_ONES = 3'b010,
                            TP_CHECK = 3'b011, TP_USRA = 3'b100, TP_USRAB = 3'b101,
                            TP_RAMP = 3'b110, TP_PN = 3'b111} adcp_tp_e;
  typedef enum logic [1:0] {CS_HOLD = 2'b00, CS_PWRUP = 2'b01, CS_RUN = 2'b10} adcp_cal_e;
endpackage

// *** adcp_spi_slave.sv ***
// three-wire serial register port: header, byte writes and byte reads
`timescale 1ns/1ps
module adcp_spi_slave
  import adcp_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // serial pins and strap pins
  input  wire logic       cs_n,
  input  wire logic       sclk,
  input  wire logic       sdio_in,
  input  wire logic [1:0] dev_addr,
  output logic            sdio_out,
  output logic            sdio_oe,
  // register side
  output logic            wr_stb,
  output logic [9:0]      wr_addr,
  output logic [7:0]      wr_data,
  output logic [9:0]      rd_addr,
  input  wire logic [7:0] rd_data
);
  logic [4:0]  s1, s2;     // pin synchroniser stages
  logic        sclk_d;     // last synced serial clock
  logic [3:0]  bitc;       // bit count in header or byte
  logic        hdr_done;   // header taken
  logic        is_rd;      // frame reads
  logic        live;       // frame addressed to us with bytes left
  logic [1:0]  left;       // bytes left minus one
  logic        cont;       // endless byte stream
  logic [9:0]  addr;       // current register
  logic [14:0] shin;       // incoming bits
  logic [7:0]  shout;      // outgoing byte
  logic        ld;         // reload outgoing byte

  // synced views and edges
  wire        cs_act = !s2[4];
  wire        sck    = s2[3];
  wire        sdi    = s2[2];
  wire        rise   = cs_act & sck & !sclk_d;
  wire        fall   = cs_act & !sck & sclk_d;
  wire [15:0] nh     = {shin, sdi};
  wire        bdone  = rise & hdr_done & (bitc[2:0] == BYTE_LAST);
  assign rd_addr = addr;

  // two-stage pin synchroniser
  always_ff @(posedge clk) begin
    s1     <= {cs_n, sclk, sdio_in, dev_addr};
    s2     <= s1;
    sclk_d <= s2[3];
  end

  // frame decoding on serial clock rises
  always_ff @(posedge clk) begin
    wr_stb <= 1'b0;
    ld     <= 1'b0;
    if (srst || !cs_act) begin
      bitc <= 4'h0;
      hdr_done <= 1'b0;
      live <= 1'b0;
    end else if (rise) begin
      shin <= nh[14:0];
      bitc <= bitc + 4'h1;
      if (!hdr_done && bitc == HDR_LAST) begin
        // header: direction, length, device address, start register
        hdr_done <= 1'b1;
        is_rd <= nh[15];
        left <= nh[14:13];
        cont <= &nh[14:13];
        live <= (nh[12:10] == {1'b0, s2[1:0]});
        addr <= nh[9:0];
        bitc <= 4'h0;
        ld <= nh[15];
      end else if (bdone) begin
        // byte complete: write, step address, count down
        wr_stb <= live & !is_rd;
        wr_addr <= addr;
        wr_data <= nh[7:0];
        addr <= addr + 10'h1;
        ld <= is_rd;
        if (left == 2'b00 && !cont) begin
          live <= 1'b0;
        end else if (!cont) begin
          left <= left - 2'b01;
        end
      end
    end
  end

  // read data leaves on serial clock falls
  always_ff @(posedge clk) begin
    if (srst || !cs_act || !live || !is_rd) begin
      sdio_oe <= 1'b0;
      sdio_out <= 1'b0;
    end else if (fall && hdr_done) begin
      sdio_oe <= 1'b1;
      sdio_out <= shout[7];
    end
    if (ld) begin
      shout <= rd_data;
    end else if (fall && hdr_done) begin
      shout <= {shout[6:0], 1'b0};
    end
  end
endmodule

// *** adcp_output_ctrl.sv ***
// converter output side: clock phase, randomizer, test patterns, calibration and resets
//
// Behaviour
// - cmos data changes on output clock rise
// - ddr lvds data changes on both edges
// - dll/decimation phase delay needs enable bit
// - dll field selects phase without decimation
// - decimation field selects phase when decimating
// - pll delay field needs no enable
// - randomizer xors upper bits with lsb
// - lsb, clock, overrange, marker stay unchanged
// - output mode zero disables data, marker and clock outputs
// - test mode drives pattern only
// - user pattern from four registers
// - pattern seven runs sixteen-bit lfsr
// - lfsr bits map to data, overrange, marker in cmos; lvds puts the marker bit on overrange and holds marker low
// - cmos all pins, lvds enabled pairs only
// - power-up calibration lasts 3 x 2^26 clocks
// - background calibration pass every 2^30 clocks
// - calibration status on pin and register
// - reset stops output and output clocks
// - hardware reset restores defaults then recalibrates
// - soft reset zero, back to one recalibrates
`timescale 1ns/1ps
module adcp_output_ctrl
  import adcp_pkg::*;
#(
  parameter logic [31:0] CAL_PWRUP_CYCLES = CAL_PWRUP_CYC,
  parameter logic [31:0] CAL_BG_CYCLES    = CAL_BG_CYC
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // hardware reset pin
  input  wire logic        hw_reset_n,
  // serial register port
  input  wire logic        spi_cs_n,
  input  wire logic        spi_sclk,
  input  wire logic        spi_sdio_in,
  output logic             spi_sdio_out,
  output logic             spi_sdio_oe,
  input  wire logic [1:0]  dev_addr,
  // timing source from the clock section
  input  wire logic        timing_src_pll,
  input  wire logic        decimation_on,
  // converted samples
  input  wire logic [13:0] sample_data,
  input  wire logic        sample_ovr,
  // output pins
  output logic [13:0]      parallel_data_outputs,
  output logic [13:0]      data_oe,
  output logic             overrange_flag,
  output logic             word_marker_clock,
  output logic             marker_oe,
  output logic             sample_output_clock,
  output logic             clock_oe,
  // calibration status and clock run flag
  output logic             cal_status_pin,
  output logic             bg_cal_pass,
  output logic             clocks_run
);
  // randomizer: upper bits xor lsb
  function automatic logic [13:0] rz(input logic [13:0] w);
    rz = {w[13:1] ^ {13{w[0]}}, w[0]};
  endfunction

  logic       hr1, hr2, hr_d;          // reset pin synchroniser
  logic [7:0] r_pwr, r_rand, r_phdll, r_phdec, r_om, r_phen, r_lane, r_pll;
  logic [7:0] upat [4];                // user pattern bytes
  logic       wr_stb;
  logic [9:0] wr_addr, rd_addr;
  logic [7:0] wr_data, rd_data;
  adcp_cal_e  cst;                     // calibration state
  logic [31:0] ccnt;                   // calibration counter
  logic [2:0] ph;                      // phase within word
  logic [15:0] pn;                     // test shift register
  logic       alt;                     // alternating pattern select
  logic [13:0] ramp;                   // ramp pattern
  logic [13:0] word;                   // current word
  logic       w_ovr;                   // current overrange
  logic [1:0] s_om;                    // word-boundary copies
  logic [2:0] s_dly;
  logic [7:0] s_lane;

  // serial register port
  adcp_spi_slave u_spi (
    .clk      (clk),
    .srst     (srst),
    .cs_n     (spi_cs_n),
    .sclk     (spi_sclk),
    .sdio_in  (spi_sdio_in),
    .dev_addr (dev_addr),
    .sdio_out (spi_sdio_out),
    .sdio_oe  (spi_sdio_oe),
    .wr_stb   (wr_stb),
    .wr_addr  (wr_addr),
    .wr_data  (wr_data),
    .rd_addr  (rd_addr),
    .rd_data  (rd_data)
  );

  // reset sources
  wire hw_act  = !hr2;
  wire reg_rst = srst | hw_act;
  wire any_rst = reg_rst | !r_pwr[B_SOFT];
  wire run     = !any_rst;

  // phase delay selection per timing source
  wire [2:0] dly = timing_src_pll ? r_pll[2:0] :
                   !r_phen[B_PHEN] ? 3'h0 :
                   decimation_on ? r_phdec[2:0] :
                   r_phdll[2:0];

  // output mode decode
  wire [2:0] tp   = r_om[B_TP +: 3];
  wire       lvds = r_om[1];
  wire       soff = (s_om == OM_OFF);
  wire       slv  = s_om[1];
  wire       tick = run & (ph == PH_LAST);
  wire       mid  = run & (ph == PH_MID);
  wire [2:0] ph_n = ph + 3'h1;
  wire [2:0] dph  = ph_n - (slv ? s_dly : 3'h0);
  wire       pfb  = pn[15] ^ pn[14] ^ pn[12] ^ pn[3];
  wire [13:0] ua  = {upat[1][5:0], upat[0]};
  wire [13:0] ub  = {upat[3][5:0], upat[2]};

  // next word: pattern or sample, never both
  wire [13:0] nw = (tp == TP_ZERO)  ? 14'h0000 :
                   (tp == TP_ONES)  ? 14'h3fff :
                   (tp == TP_CHECK) ? (alt ? CHK_B : CHK_A) :
                   (tp == TP_USRA)  ? ua :
                   (tp == TP_USRAB) ? (alt ? ub : ua) :
                   (tp == TP_RAMP)  ? ramp :
                   (tp == TP_PN)    ? pn[15:2] :
                   r_rand[B_RAND] ? rz(sample_data) :
                   sample_data;
  wire nov = (tp == TP_PN) ? pn[15] : (tp == TP_NONE) & sample_ovr;
  wire nwk = (tp == TP_PN) & pn[14];

  // register read selection
  assign rd_data = (rd_addr == A_PWR)   ? r_pwr :
                   (rd_addr == A_RAND)  ? r_rand :
                   (rd_addr == A_PHDLL) ? r_phdll :
                   (rd_addr == A_PHDEC) ? r_phdec :
                   (rd_addr == A_OMODE) ? r_om :
                   (rd_addr == A_PHEN)  ? r_phen :
                   (rd_addr == A_LANE)  ? r_lane :
                   (rd_addr == A_PLL)   ? r_pll :
                   (rd_addr >= A_UP0 && rd_addr <= A_UP3) ? upat[rd_addr[1:0]] :
                   (rd_addr == A_CAL)   ? {7'h00, cal_status_pin} :
                   RV_ZERO;

  // reset pin synchroniser and edge history
  always_ff @(posedge clk) begin
    hr1  <= hw_reset_n;
    hr2  <= hr1;
    hr_d <= hr2;
  end

  // user registers: defaults while a hard reset is held
  always_ff @(posedge clk) begin
    if (reg_rst) begin
      r_pwr <= RV_PWR;
      r_rand <= RV_ZERO;
      r_phdll <= RV_ZERO;
      r_phdec <= RV_ZERO;
      r_om <= RV_OMODE;
      r_phen <= RV_ZERO;
      r_lane <= RV_LANE;
      r_pll <= RV_ZERO;
      upat <= '{default: RV_ZERO};
    end else if (wr_stb) begin
      unique case (wr_addr)
        A_PWR:   r_pwr <= wr_data;
        A_RAND:  r_rand <= wr_data;
        A_PHDLL: r_phdll <= wr_data;
        A_PHDEC: r_phdec <= wr_data;
        A_OMODE: r_om <= wr_data;
        A_PHEN:  r_phen <= wr_data;
        A_LANE:  r_lane <= wr_data;
        A_PLL:   r_pll <= wr_data;
        default: begin
          if (wr_addr >= A_UP0 && wr_addr <= A_UP3) begin
            upat[wr_addr[1:0]] <= wr_data;
          end
        end
      endcase
    end
  end

  // calibration sequencing
  always_ff @(posedge clk) begin
    bg_cal_pass <= 1'b0;
    if (any_rst) begin
      cst <= CS_HOLD;
      ccnt <= 32'h0;
    end else begin
      ccnt <= ccnt + 32'h1;
      unique case (cst)
        CS_HOLD: begin
          cst <= CS_PWRUP;
          ccnt <= 32'h0;
        end
        CS_PWRUP: begin
          if (ccnt == CAL_PWRUP_CYCLES - 32'h1) begin
            cst <= CS_RUN;
            ccnt <= 32'h0;
          end
        end
        CS_RUN: begin
          if (ccnt == CAL_BG_CYCLES - 32'h1) begin
            bg_cal_pass <= 1'b1;
            ccnt <= 32'h0;
          end
        end
        default: cst <= CS_HOLD;
      endcase
    end
  end

  // status pin: low from any reset until calibration ends
  always_ff @(posedge clk) begin
    cal_status_pin <= run & (cst == CS_RUN);
    clocks_run <= run;
  end

  // word phase, pattern generators, word-boundary copies
  always_ff @(posedge clk) begin
    if (any_rst) begin
      ph <= 3'h0;
      pn <= PN_SEED;
      alt <= 1'b0;
      ramp <= 14'h0000;
      s_om <= OM_OFF;
      s_dly <= 3'h0;
      s_lane <= RV_ZERO;
      word <= 14'h0000;
      w_ovr <= 1'b0;
    end else begin
      ph <= ph_n;
      if (tick) begin
        pn <= {pn[14:0], pfb};
        alt <= !alt;
        ramp <= ramp + 14'h0001;
        s_om <= r_om[1:0];
        s_dly <= dly;
        s_lane <= r_lane;
        word <= nw;
        w_ovr <= nov;
      end
    end
  end

  // pin drivers: cmos once a word, lvds twice a word
  always_ff @(posedge clk) begin
    if (any_rst) begin
      parallel_data_outputs <= 14'h0000;
      overrange_flag <= 1'b0;
      word_marker_clock <= 1'b0;
    end else if (tick) begin
      parallel_data_outputs <= lvds ? {7'h00, nw[13:7]} : nw;
      overrange_flag <= lvds ? nwk : nov;
      word_marker_clock <= !lvds & nwk;
    end else if (mid && slv) begin
      parallel_data_outputs <= {7'h00, word[6:0]};
      overrange_flag <= w_ovr;
    end
  end

  // output clock and enables
  always_ff @(posedge clk) begin
    if (any_rst) begin
      sample_output_clock <= 1'b0;
      clock_oe <= 1'b0;
      data_oe <= 14'h0000;
      marker_oe <= 1'b0;
    end else begin
      sample_output_clock <= !soff & !dph[2];
      clock_oe <= !soff;
      data_oe <= soff ? 14'h0000 :
                 slv ? {7'h00, s_lane[6:0]} : 14'h3fff;
      marker_oe <= !soff & (!slv | s_lane[7]);
    end
  end

  // checks
  sequence s_cmos_step;
    (s_om == OM_CMOS) && $stable(s_om) && $changed(parallel_data_outputs);
  endsequence
  sequence s_soft_cycle;
    !reg_rst && !r_pwr[B_SOFT] ##1 !reg_rst && r_pwr[B_SOFT];
  endsequence

  chk_cmos_rise_edge: assert property (@(posedge clk) disable iff (srst)
    s_cmos_step |-> $rose(sample_output_clock))
    else $error("cmos data moved without clock rise");
  chk_output_disable: assert property (@(posedge clk) disable iff (srst)
    run && soff |=> !clock_oe && data_oe == 14'h0000 && !marker_oe)
    else $error("outputs enabled in off mode");
  chk_rand_word: assert property (@(posedge clk) disable iff (srst)
    tick && tp == TP_NONE && r_rand[B_RAND] && !any_rst
      |=> word == rz($past(sample_data)) && w_ovr == $past(sample_ovr))
    else $error("randomized word wrong");
  chk_pn_step: assert property (@(posedge clk) disable iff (srst)
    tick && !any_rst |=> pn == {$past(pn[14:0]), $past(pfb)})
    else $error("lfsr step wrong");
  chk_pn_map: assert property (@(posedge clk) disable iff (srst)
    tick && tp == TP_PN && !lvds |=> parallel_data_outputs == $past(pn[15:2])
      && overrange_flag == $past(pn[15]) && word_marker_clock == $past(pn[14]))
    else $error("lfsr bits not on pins");
  chk_user_word: assert property (@(posedge clk) disable iff (srst)
    tick && tp == TP_USRA && !any_rst |=> word == $past(ua))
    else $error("user pattern not used");
  chk_reset_quiet: assert property (@(posedge clk) disable iff (srst)
    any_rst |=> !clock_oe && !sample_output_clock && !clocks_run)
    else $error("outputs alive in reset");
  chk_status_low: assert property (@(posedge clk) disable iff (srst)
    any_rst |=> !cal_status_pin [*2])
    else $error("status high during reset");
  chk_soft_recal: assert property (@(posedge clk) disable iff (srst)
    s_soft_cycle |=> cst == CS_PWRUP ##1 !cal_status_pin)
    else $error("soft reset release did not recalibrate");
  chk_pwrup_end: assert property (@(posedge clk) disable iff (srst)
    cst == CS_PWRUP && ccnt == CAL_PWRUP_CYCLES - 32'h1 && run
      |=> cst == CS_RUN ##1 cal_status_pin)
    else $error("power-up calibration end wrong");
  chk_dly_gate: assert property (@(posedge clk) disable iff (srst)
    tick && !timing_src_pll && !r_phen[B_PHEN] |=> s_dly == 3'h0)
    else $error("phase delay used while disabled");
  chk_dly_dll: assert property (@(posedge clk) disable iff (srst)
    tick && !timing_src_pll && r_phen[B_PHEN] && !decimation_on
      |=> s_dly == $past(r_phdll[2:0]))
    else $error("dll phase field not used");
  chk_dly_dec: assert property (@(posedge clk) disable iff (srst)
    tick && !timing_src_pll && r_phen[B_PHEN] && decimation_on
      |=> s_dly == $past(r_phdec[2:0]))
    else $error("decimation phase field not used");
  chk_dly_pll: assert property (@(posedge clk) disable iff (srst)
    tick && timing_src_pll |=> s_dly == $past(r_pll[2:0]))
    else $error("pll delay field not used");
  chk_lvds_fall: assert property (@(posedge clk) disable iff (srst)
    mid && slv && s_dly == 3'h0
      |=> $fell(sample_output_clock) && parallel_data_outputs == {7'h00, $past(word[6:0])})
    else $error("lvds second half not on clock fall");
  chk_hw_restart: assert property (@(posedge clk) disable iff (srst)
    hr2 && !hr_d |-> cst == CS_HOLD && r_om == RV_OMODE ##1 cst == CS_PWRUP)
    else $error("hardware reset release did not restore and recalibrate");
endmodule

// *** adcp_host_model.sv ***
// host capture model: latches output words on the falling output clock and undoes the randomizer
`timescale 1ns/1ps
module adcp_host_model (
  // clock
  input  wire logic        clk,
  // device output pins
  input  wire logic [13:0] q,
  input  wire logic        ovf,
  input  wire logic        mark,
  input  wire logic        oclk,
  input  wire logic        oclk_oe,
  // captured word and edge watch
  output logic [13:0]      word,
  output logic [13:0]      plain,
  output logic             w_ovf,
  output logic             w_mark,
  output int               n_words,
  output int               n_bad_edge
);
  logic        oclk_q; // output clock one cycle ago
  logic [13:0] q_q;    // data one cycle ago
  // counters are two-state and start at zero

  // capture on the falling output clock, the safe point for full-rate data
  always @(posedge clk) begin
    oclk_q <= oclk;
    q_q    <= q;
    if (oclk_q && !oclk && oclk_oe) begin
      word    <= q;
      plain   <= {q[13:1] ^ {13{q[0]}}, q[0]};
      w_ovf   <= ovf;
      w_mark  <= mark;
      n_words <= n_words + 1;
    end
    // data may only move together with a rising output clock
    if (oclk_oe && q !== q_q && !(oclk && !oclk_q)) begin
      n_bad_edge <= n_bad_edge + 1;
    end
  end
endmodule

// *** testbench.sv ***
// testbench: serial register access, patterns, randomizer, output disable, resets, calibration
`timescale 1ns/1ps
module testbench;
  import adcp_pkg::*;
  // stimulus and pins
  logic        clk, srst, hw_reset_n, spi_cs_n, spi_sclk, tb_sdio;
  logic [1:0]  dev_addr;
  logic [13:0] sample_data, data_q, data_oe, word, plain, ua, ub, w1, d14;
  logic        sample_ovr, spi_sdio_out, spi_sdio_oe, ovf_q, mark_q, marker_oe;
  logic        oclk, clock_oe, cal_status_pin, bg_cal_pass, clocks_run, w_ovf, w_mark;
  logic [7:0]  junk;
  logic        pll_src, dec_on; // timing source levels
  logic [31:0] seed;
  int          n_mismatch, checked, cycles, n_words, n_bad_edge, pulses;
  wire         sdio = spi_sdio_oe ? spi_sdio_out : tb_sdio; // shared serial data line
  // defaults table: address and value after reset, last one unmapped
  logic [9:0]  ra [5] = '{A_PWR, A_OMODE, A_RAND, A_UP0, 10'h010};
  logic [7:0]  rv [5] = '{RV_PWR, RV_OMODE, RV_ZERO, RV_ZERO, RV_ZERO};

  adcp_output_ctrl #(.CAL_PWRUP_CYCLES(32'h40), .CAL_BG_CYCLES(32'hc8)) i_dut (
    .clk(clk), .srst(srst), .hw_reset_n(hw_reset_n), .spi_cs_n(spi_cs_n),
    .spi_sclk(spi_sclk), .spi_sdio_in(sdio), .spi_sdio_out(spi_sdio_out),
    .spi_sdio_oe(spi_sdio_oe), .dev_addr(dev_addr), .timing_src_pll(pll_src),
    .decimation_on(dec_on), .sample_data(sample_data), .sample_ovr(sample_ovr),
    .parallel_data_outputs(data_q), .data_oe(data_oe), .overrange_flag(ovf_q),
    .word_marker_clock(mark_q), .marker_oe(marker_oe), .sample_output_clock(oclk),
    .clock_oe(clock_oe), .cal_status_pin(cal_status_pin), .bg_cal_pass(bg_cal_pass),
    .clocks_run(clocks_run));

  adcp_host_model i_host (
    .clk(clk), .q(data_q), .ovf(ovf_q), .mark(mark_q), .oclk(oclk), .oclk_oe(clock_oe),
    .word(word), .plain(plain), .w_ovf(w_ovf), .w_mark(w_mark), .n_words(n_words),
    .n_bad_edge(n_bad_edge));

  // 100 mhz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  // bench random source
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // expected randomized word
  function automatic logic [13:0] exp_rnd(input logic [13:0] d);
    return {d[13:1] ^ {13{d[0]}}, d[0]};
  endfunction

  // expected fixed patterns
  function automatic logic [13:0] exp_pat(input logic [2:0] tp, input logic [13:0] a);
    case (tp)
      3'b001:  exp_pat = 14'h0000;
      3'b010:  exp_pat = 14'h3fff;
      default: exp_pat = a;
    endcase
  endfunction

  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one serial frame with one data byte; sclk idles low between frames
  task automatic spi(input logic rw, input logic [2:0] dev, input logic [9:0] a,
                     input logic [7:0] wd, output logic [7:0] rd);
    logic [23:0] fr;
    fr = {rw, 2'b00, dev, a, wd};
    @(negedge clk);
    spi_cs_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      spi_sclk = 1'b0;
      tb_sdio  = (rw && i < 8) ? ~tb_sdio : fr[i]; // released line keeps toggling
      #62.5;
      if (i < 8) rd[i] = sdio;
      spi_sclk = 1'b1;
      #62.5;
    end
    spi_sclk = 1'b0;
    #62.5;
    spi_cs_n = 1'b1;
    repeat (10) @(negedge clk);
  endtask

  // register write and checked read
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    spi(1'b0, {1'b0, dev_addr}, a, d, junk);
  endtask
  task automatic rdc(input logic [9:0] a, input logic [7:0] exp);
    logic [7:0] d;
    spi(1'b1, {1'b0, dev_addr}, a, 8'h00, d);
    chk(d, exp);
  endtask

  // wait for n captured words, bounded
  task automatic words(input int n);
    int s;
    s = n_words;
    for (int k = 0; k < 400 && n_words < s + n; k++) @(negedge clk);
  endtask

  // calibration status low for a while, then high
  task automatic cal_seq();
    repeat (40) @(negedge clk);
    chk(cal_status_pin, 1'b0);
    repeat (60) @(negedge clk);
    chk(cal_status_pin, 1'b1);
  endtask

  // closing report
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    srst = 1'b1;
    hw_reset_n = 1'b1;
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
    tb_sdio = 1'b0;
    dev_addr = 2'b10;
    sample_data = 14'h0000;
    sample_ovr = 1'b0;
    pll_src = 1'b0;
    dec_on = 1'b0;
    seed = 32'h141a1c18;
    repeat (5) @(negedge clk);
    srst = 1'b0;
    cal_seq();
    pulses = 0;
    for (int k = 0; k < 400; k++) begin
      @(negedge clk);
      pulses += int'(bg_cal_pass);
    end
    chk(pulses, 2);
    rdc(A_CAL, 8'h01);
    $display("test calibration done");
    // defaults, read-only status, unmapped place, foreign device address
    foreach (ra[i]) rdc(ra[i], rv[i]);
    wr(A_CAL, 8'h00);
    rdc(A_CAL, 8'h01);
    spi(1'b0, 3'b001, A_UP0, 8'h5a, junk);
    rdc(A_UP0, 8'h00);
    $display("test registers done");
    // every test pattern, with live samples that must not leak
    seed = lfsr(seed);
    ua = seed[13:0];
    seed = lfsr(seed);
    ub = seed[13:0];
    sample_data = seed[27:14];
    wr(A_UP0, ua[7:0]);
    wr(A_UP0 + 10'h001, {2'b00, ua[13:8]});
    wr(A_UP3 - 10'h001, ub[7:0]);
    wr(A_UP3, {2'b00, ub[13:8]});
    for (int t = 1; t < 8; t++) begin
      wr(A_OMODE, {3'b000, t[2:0], 2'b01});
      words(3);
      w1 = word;
      words(1);
      d14 = word - w1;
      case (t)
        3: chk(w1 ^ word, CHK_A ^ CHK_B);
        5: chk(w1 ^ word, ua ^ ub);
        6: chk(d14, 14'h0001);
        7: chk(word[13:1], w1[12:0]);
        default: chk(word, exp_pat(t[2:0], ua));
      endcase
    end
    for (int k = 0; k < 16; k++) begin
      w1 = word;
      words(1);
      chk(word[13:1], w1[12:0]);
      chk({w_ovf, w_mark}, word[13:12]);
    end
    $display("test patterns done");
    // randomizer on random samples
    wr(A_OMODE, RV_OMODE);
    wr(A_RAND, 8'h01);
    for (int k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      sample_data = seed[13:0];
      sample_ovr = seed[20];
      words(3);
      chk(word, exp_rnd(sample_data));
      chk(plain, sample_data);
      chk(w_ovf, sample_ovr);
    end
    wr(A_RAND, 8'h00);
    words(3);
    chk(word, sample_data);
    chk(n_bad_edge, 0);
    $display("test randomizer done");
    // lvds halves and output clock phase per timing source
    wr(A_PHDLL, 8'h04);
    wr(A_OMODE, 8'h12);
    words(3);
    chk(word, {7'h00, ua[6:0]});
    chk(data_oe, 14'h007f);
    wr(A_PHEN, 8'h01);
    words(3);
    chk(word, {7'h00, ua[13:7]});
    dec_on = 1'b1;
    words(3);
    chk(word, {7'h00, ua[6:0]});
    pll_src = 1'b1;
    wr(A_PHEN, 8'h00);
    wr(A_PLL, 8'h04);
    words(3);
    chk(word, {7'h00, ua[13:7]});
    pll_src = 1'b0;
    dec_on = 1'b0;
    $display("test lvds phase done");
    // output disable
    wr(A_OMODE, 8'h00);
    repeat (20) @(negedge clk);
    chk({clock_oe, data_oe, marker_oe, oclk}, 17'h00000);
    wr(A_OMODE, RV_OMODE);
    $display("test disable done");
    // soft reset keeps user registers and recalibrates on release
    wr(A_PWR, 8'h00);
    chk({clocks_run, clock_oe, cal_status_pin}, 3'b000);
    rdc(A_UP0, ua[7:0]);
    wr(A_PWR, RV_PWR);
    cal_seq();
    $display("test soft reset done");
    // hardware reset restores defaults and recalibrates
    hw_reset_n = 1'b0;
    repeat (10) @(negedge clk);
    chk({clocks_run, clock_oe}, 2'b00);
    hw_reset_n = 1'b1;
    cal_seq();
    rdc(A_UP0, 8'h00);
    rdc(A_OMODE, RV_OMODE);
    $display("test hardware reset done");
    end_of_test();
  end
endmodule
